// [core/cmp_skip_page_regs.vh]
// constants for the compare/test/skip and page arithmetic unit
// assumes inclusion by bare name from design files under core/
`ifndef CMP_SKIP_PAGE_REGS_VH
`define CMP_SKIP_PAGE_REGS_VH

// first opcode bytes
`define PFX_REG 8'h74
`define PFX_SREG 8'h64
`define OP_NE_ACC 8'h67
`define OP_EQ_ACC 8'h77
`define OP_ON_ACC 8'h47
`define OP_OFF_ACC 8'h57

// second byte, register forms: upper five bits
`define SEL_NE_REG 5'h0d
`define SEL_EQ_REG 5'h0f
`define SEL_ON_REG 5'h09
`define SEL_OFF_REG 5'h0b

// second byte, special-register forms: bits 6..3
`define SEL_NE_SREG 4'hd
`define SEL_EQ_SREG 4'hf
`define SEL_ON_SREG 4'h9
`define SEL_OFF_SREG 4'hb

// second byte, page forms
`define OP_PAGE_ADD 8'hc0
`define OP_PAGE_ADC 8'hd0
`define OP_PAGE_ADDNC 8'ha0
`define OP_PAGE_SUB 8'he0
`define OP_PAGE_SBB 8'hf0
`define OP_PAGE_SUBNB 8'hb0

// register codes
`define REG_PAGE 3'h0
`define REG_ACC 3'h1

// lengths and state counts
`define LEN_SHORT 2'h2
`define LEN_LONG 2'h3
`define ST_ACC 5'h07
`define ST_ACC_ALT 5'h07
`define ST_REG 5'h0b
`define ST_REG_ALT 5'h0b
`define ST_SREG 5'h0e
`define ST_SREG_ALT 5'h0b
`define ST_PAGE 5'h0e
`define ST_PAGE_ALT 5'h0b
`define ST_EXEC_USED 5'h03

// flag vector bit positions
`define FLG_ZERO 5
`define FLG_PASS 4
`define FLG_HALF 3
`define FLG_CARRY 2
`define FLG_WORD 1
`define FLG_BYTE 0

// alu operations
`define ALU_ADD 2'h0
`define ALU_SUB 2'h1
`define ALU_AND 2'h2

`endif

// [core/alu_core.v]
// 8-bit add / subtract / and with carry, half carry and zero
// assumes purely combinational use by the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "cmp_skip_page_regs.vh"

module alu_core (
  input wire [1:0] op_i,
  input wire [7:0] a_i,
  input wire [7:0] b_i,
  input wire cin_i,
  output wire [7:0] res_o,
  output wire carry_o,
  output wire half_o,
  output wire zero_o
);

  wire [8:0] sum_full;
  wire [8:0] dif_full;
  wire [4:0] sum_low;
  wire [4:0] dif_low;
  reg [7:0] res;
  reg carry;
  reg half;

  assign sum_full = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
  assign dif_full = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
  assign sum_low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
  assign dif_low = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin_i};

  always @* begin
    case (op_i)
      `ALU_ADD: begin
        res = sum_full[7:0];
        carry = sum_full[8];
        half = sum_low[4];
      end
      `ALU_SUB: begin
        // carry and half carry mean borrow here
        res = dif_full[7:0];
        carry = dif_full[8];
        half = dif_low[4];
      end
      default: begin
        res = a_i & b_i;
        carry = 1'b0;
        half = 1'b0;
      end
    endcase
  end

  assign res_o = res;
  assign carry_o = carry;
  assign half_o = half;
  assign zero_o = (res == 8'h00);

endmodule // alu_core

`default_nettype wire

// [core/cmp_skip_page_unit.v]
// execution unit for immediate compare/bit-test with skip and page arithmetic
// assumes a sequencer on core_clk_i that offers whole instructions and waits for done_o
`timescale 1ns/1ps
`default_nettype none
`include "cmp_skip_page_regs.vh"

// Functional notes
// [RQ1] register field 0..7 picks page, accumulator, B, C, D, E, H, L
// [RQ2] special field picks eleven registers; only 0-3, 5-9, B, D are valid
// [RQ3] not-equal compare subtracts without storing, skips on nonzero difference
// [RQ4] equal compare subtracts without storing, skips on zero difference
// [RQ5] compares set zero, skip, half carry, carry; clear both chained-load flags
// [RQ6] accumulator immediate forms: two bytes, 7 states, alternate 7
// [RQ7] register immediate forms: three bytes, 11 states, alternate 11
// [RQ8] special-register forms: three bytes, 14 states, alternate 11
// [RQ9] bit-on test ANDs without storing, skips when any masked bit is one
// [RQ10] bit-off test ANDs without storing, skips when all masked bits zero
// [RQ11] bit tests set zero and skip, clear chained-load flags, keep carries
// [RQ12] register bit-off test is prefix 74h then 01011 and register code
// [RQ13] page operand address is page register high, third byte low
// [RQ14] page add stores sum in accumulator, sets zero/carries, clears skip
// [RQ15] page add-with-carry also adds the incoming carry flag
// [RQ16] page add-skip stores sum, skips when no carry out
// [RQ17] page subtract stores difference, sets zero/carries, clears skip
// [RQ18] page subtract-with-borrow also subtracts the incoming carry flag
// [RQ19] page subtract-skip stores difference, skips when no borrow
// [RQ20] all page arithmetic: three bytes, 14 states, alternate 11
// [RQ21] software loads the page register before any page instruction
// [RQ22] a skip discards the next whole instruction without any effect
// [RQ23] special-register forms only read the special register
module cmp_skip_page_unit (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire instr_valid_i,
  input wire [7:0] byte1_i,
  input wire [7:0] byte2_i,
  input wire [7:0] byte3_i,
  input wire [1:0] other_len_i,
  input wire [4:0] other_alt_states_i,
  input wire reg_wr_i,
  input wire [2:0] reg_wr_sel_i,
  input wire [7:0] reg_wr_data_i,
  input wire flag_wr_i,
  input wire [5:0] flag_wr_data_i,
  input wire [7:0] mem_data_i,
  input wire [7:0] special_data_i,
  output wire busy_o,
  output wire done_o,
  output wire discarded_o,
  output wire foreign_o,
  output wire [1:0] instr_len_o,
  output wire [4:0] instr_states_o,
  output wire mem_rd_o,
  output wire [15:0] mem_addr_o,
  output wire special_rd_o,
  output wire [3:0] special_set_sel_o,
  output wire [7:0] acc_o,
  output wire [7:0] page_o,
  output wire zero_flag_o,
  output wire pass_next_flag_o,
  output wire half_carry_flag_o,
  output wire carry_flag_o,
  output wire chained_load_flag_word_o,
  output wire chained_load_flag_byte_o
);

  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_EXEC = 2'h2;
  localparam ST_WAIT = 2'h3;
  localparam K_NE = 4'h0;
  localparam K_EQ = 4'h1;
  localparam K_ON = 4'h2;
  localparam K_OFF = 4'h3;
  localparam K_ADD = 4'h4;
  localparam K_ADC = 4'h5;
  localparam K_ADDNC = 4'h6;
  localparam K_SUB = 4'h7;
  localparam K_SBB = 4'h8;
  localparam K_SUBNB = 4'h9;
  localparam SRC_REG = 2'h0;
  localparam SRC_SPECIAL = 2'h1;
  localparam SRC_MEM = 2'h2;
  // decoded word: {known, kind[3:0], src[1:0], reg[2:0], len[1:0], states[4:0], alt[4:0]}
  localparam DW = 22;
  function sreg_code_ok;
    input [3:0] code;
    begin
      case (code)
        4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hb, 4'hd: sreg_code_ok = 1'b1; // [RQ2]
        default: sreg_code_ok = 1'b0;
      endcase
    end
  endfunction

  function [DW-1:0] decode;
    input [7:0] b1;
    input [7:0] b2;
    reg [3:0] sop;
    begin
      decode = {DW{1'b0}};
      sop = b2[6:3];
      case (b1)
        `OP_NE_ACC: decode = {1'b1, K_NE, SRC_REG, `REG_ACC, `LEN_SHORT, `ST_ACC, `ST_ACC_ALT}; // [RQ6]
        `OP_EQ_ACC: decode = {1'b1, K_EQ, SRC_REG, `REG_ACC, `LEN_SHORT, `ST_ACC, `ST_ACC_ALT}; // [RQ6]
        `OP_ON_ACC: decode = {1'b1, K_ON, SRC_REG, `REG_ACC, `LEN_SHORT, `ST_ACC, `ST_ACC_ALT}; // [RQ6]
        `OP_OFF_ACC: decode = {1'b1, K_OFF, SRC_REG, `REG_ACC, `LEN_SHORT, `ST_ACC, `ST_ACC_ALT}; // [RQ6]
        `PFX_REG: begin
          case (b2[7:3])
            `SEL_NE_REG: decode = {1'b1, K_NE, SRC_REG, b2[2:0], `LEN_LONG, `ST_REG, `ST_REG_ALT}; // [RQ1] [RQ7]
            `SEL_EQ_REG: decode = {1'b1, K_EQ, SRC_REG, b2[2:0], `LEN_LONG, `ST_REG, `ST_REG_ALT}; // [RQ7]
            `SEL_ON_REG: decode = {1'b1, K_ON, SRC_REG, b2[2:0], `LEN_LONG, `ST_REG, `ST_REG_ALT}; // [RQ7]
            `SEL_OFF_REG: decode = {1'b1, K_OFF, SRC_REG, b2[2:0], `LEN_LONG, `ST_REG, `ST_REG_ALT}; // [RQ12]
            default: begin
              case (b2)
                `OP_PAGE_ADD: decode = {1'b1, K_ADD, SRC_MEM, 3'h0, `LEN_LONG, `ST_PAGE, `ST_PAGE_ALT}; // [RQ20]
                `OP_PAGE_ADC: decode = {1'b1, K_ADC, SRC_MEM, 3'h0, `LEN_LONG, `ST_PAGE, `ST_PAGE_ALT}; // [RQ20]
                `OP_PAGE_ADDNC: decode = {1'b1, K_ADDNC, SRC_MEM, 3'h0, `LEN_LONG, `ST_PAGE, `ST_PAGE_ALT}; // [RQ20]
                `OP_PAGE_SUB: decode = {1'b1, K_SUB, SRC_MEM, 3'h0, `LEN_LONG, `ST_PAGE, `ST_PAGE_ALT}; // [RQ20]
                `OP_PAGE_SBB: decode = {1'b1, K_SBB, SRC_MEM, 3'h0, `LEN_LONG, `ST_PAGE, `ST_PAGE_ALT}; // [RQ20]
                `OP_PAGE_SUBNB: decode = {1'b1, K_SUBNB, SRC_MEM, 3'h0, `LEN_LONG, `ST_PAGE, `ST_PAGE_ALT}; // [RQ20]
                default: decode = {DW{1'b0}};
              endcase
            end
          endcase
        end
        `PFX_SREG: begin
          if (sreg_code_ok({b2[7], b2[2:0]})) begin
            case (sop)
              `SEL_NE_SREG: decode = {1'b1, K_NE, SRC_SPECIAL, 3'h0, `LEN_LONG, `ST_SREG, `ST_SREG_ALT}; // [RQ8]
              `SEL_EQ_SREG: decode = {1'b1, K_EQ, SRC_SPECIAL, 3'h0, `LEN_LONG, `ST_SREG, `ST_SREG_ALT}; // [RQ8]
              `SEL_ON_SREG: decode = {1'b1, K_ON, SRC_SPECIAL, 3'h0, `LEN_LONG, `ST_SREG, `ST_SREG_ALT}; // [RQ8]
              `SEL_OFF_SREG: decode = {1'b1, K_OFF, SRC_SPECIAL, 3'h0, `LEN_LONG, `ST_SREG, `ST_SREG_ALT}; // [RQ8]
              default: decode = {DW{1'b0}};
            endcase
          end
        end
        default: decode = {DW{1'b0}};
      endcase
    end
  endfunction
  reg [1:0] state;
  reg [7:0] regs [0:7];
  reg [5:0] flags;
  reg [4:0] cnt;
  reg [3:0] kind;
  reg [1:0] src;
  reg [2:0] rsel;
  reg [7:0] imm;
  reg busy;
  reg done;
  reg discarded;
  reg foreign;
  reg [1:0] len;
  reg [4:0] states;
  reg mem_rd;
  reg [15:0] mem_addr;
  reg special_rd;
  reg [3:0] special_sel;
  integer i;
  wire [DW-1:0] dec;
  wire dec_known;
  wire [3:0] dec_kind;
  wire [1:0] dec_src;
  wire [2:0] dec_reg;
  wire [1:0] dec_len;
  wire [4:0] dec_states;
  wire [4:0] dec_alt;
  assign dec = decode(byte1_i, byte2_i);
  assign dec_known = dec[21];
  assign dec_kind = dec[20:17];
  assign dec_src = dec[16:15];
  assign dec_reg = dec[14:12];
  assign dec_len = dec[11:10];
  assign dec_states = dec[9:5];
  assign dec_alt = dec[4:0];
  reg [7:0] operand;
  reg [1:0] alu_op;
  reg alu_cin;
  reg skip;
  reg [5:0] next_flags;
  reg acc_write;
  wire [7:0] alu_res;
  wire alu_carry;
  wire alu_half;
  wire alu_zero;
  always @* begin
    case (src)
      SRC_SPECIAL: operand = special_data_i;
      SRC_MEM: operand = mem_data_i;
      default: operand = regs[rsel];
    endcase
  end
  alu_core u_alu (
    .op_i(alu_op),
    .a_i(src == SRC_MEM ? regs[`REG_ACC] : operand),
    .b_i(src == SRC_MEM ? operand : imm),
    .cin_i(alu_cin),
    .res_o(alu_res),
    .carry_o(alu_carry),
    .half_o(alu_half),
    .zero_o(alu_zero)
  );
  always @* begin
    alu_op = `ALU_SUB;
    alu_cin = 1'b0;
    skip = 1'b0;
    acc_write = 1'b0;
    next_flags = flags;
    next_flags[`FLG_WORD] = 1'b0; // [RQ5] [RQ11]
    next_flags[`FLG_BYTE] = 1'b0; // [RQ5] [RQ11]
    next_flags[`FLG_ZERO] = alu_zero;
    next_flags[`FLG_HALF] = alu_half;
    next_flags[`FLG_CARRY] = alu_carry;
    case (kind)
      K_NE: skip = !alu_zero; // [RQ3]
      K_EQ: skip = alu_zero; // [RQ4]
      K_ON: begin
        alu_op = `ALU_AND;
        skip = !alu_zero; // [RQ9]
      end
      K_OFF: begin
        alu_op = `ALU_AND;
        skip = alu_zero; // [RQ10]
      end
      K_ADD: begin
        alu_op = `ALU_ADD;
        acc_write = 1'b1; // [RQ14]
      end
      K_ADC: begin
        alu_op = `ALU_ADD;
        alu_cin = flags[`FLG_CARRY]; // [RQ15]
        acc_write = 1'b1;
      end
      K_ADDNC: begin
        alu_op = `ALU_ADD;
        acc_write = 1'b1;
        skip = !alu_carry; // [RQ16]
      end
      K_SUB: acc_write = 1'b1; // [RQ17]
      K_SBB: begin
        alu_cin = flags[`FLG_CARRY]; // [RQ18]
        acc_write = 1'b1;
      end
      K_SUBNB: begin
        acc_write = 1'b1;
        skip = !alu_carry; // [RQ19]
      end
      default: skip = 1'b0;
    endcase
    if (kind == K_ON || kind == K_OFF) begin
      next_flags[`FLG_HALF] = flags[`FLG_HALF]; // [RQ11]
      next_flags[`FLG_CARRY] = flags[`FLG_CARRY]; // [RQ11]
    end
    next_flags[`FLG_PASS] = skip; // [RQ5] [RQ14] [RQ17]
  end
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      for (i = 0; i < 8; i = i + 1) begin
        regs[i] <= 8'h00;
      end
      flags <= 6'h00;
      cnt <= 5'h00;
      kind <= 4'h0;
      src <= 2'h0;
      rsel <= 3'h0;
      imm <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      discarded <= 1'b0;
      foreign <= 1'b0;
      len <= 2'h0;
      states <= 5'h00;
      mem_rd <= 1'b0;
      mem_addr <= 16'h0000;
      special_rd <= 1'b0;
      special_sel <= 4'h0;
    end else if (ce_i) begin
      done <= 1'b0;
      mem_rd <= 1'b0;
      special_rd <= 1'b0;
      if (reg_wr_i && !busy) begin
        regs[reg_wr_sel_i] <= reg_wr_data_i;
      end
      if (flag_wr_i && !busy) begin
        flags <= flag_wr_data_i;
      end
      case (state)
        ST_IDLE: begin
          if (instr_valid_i) begin
            busy <= 1'b1;
            discarded <= 1'b0;
            foreign <= 1'b0;
            if (flags[`FLG_PASS]) begin
              // fetched but thrown away, only the flag moves
              flags[`FLG_PASS] <= 1'b0; // [RQ22]
              discarded <= 1'b1; // [RQ22]
              len <= dec_known ? dec_len : other_len_i; // [RQ22]
              states <= dec_known ? dec_alt : other_alt_states_i;
              cnt <= (dec_known ? dec_alt : other_alt_states_i) - 5'h01;
              state <= ST_WAIT;
            end else if (!dec_known) begin
              foreign <= 1'b1;
              len <= other_len_i;
              states <= 5'h01;
              cnt <= 5'h00;
              state <= ST_WAIT;
            end else begin
              kind <= dec_kind;
              src <= dec_src;
              rsel <= dec_reg; // [RQ1]
              imm <= (dec_len == `LEN_SHORT) ? byte2_i : byte3_i;
              len <= dec_len;
              states <= dec_states;
              cnt <= dec_states - `ST_EXEC_USED;
              mem_addr <= {regs[`REG_PAGE], byte3_i}; // [RQ13] [RQ21]
              mem_rd <= (dec_src == SRC_MEM);
              special_sel <= {byte2_i[7], byte2_i[2:0]}; // [RQ2]
              special_rd <= (dec_src == SRC_SPECIAL); // [RQ23]
              state <= ST_READ;
            end
          end
        end
        ST_READ: state <= ST_EXEC;
        ST_EXEC: begin
          flags <= next_flags;
          if (acc_write) begin
            regs[`REG_ACC] <= alu_res; // [RQ14] [RQ17]
          end
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (cnt == 5'h00) begin
            done <= 1'b1;
            busy <= 1'b0;
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 5'h01;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  assign busy_o = busy;
  assign done_o = done;
  assign discarded_o = discarded;
  assign foreign_o = foreign;
  assign instr_len_o = len;
  assign instr_states_o = states;
  assign mem_rd_o = mem_rd;
  assign mem_addr_o = mem_addr;
  assign special_rd_o = special_rd;
  assign special_set_sel_o = special_sel;
  assign acc_o = regs[`REG_ACC];
  assign page_o = regs[`REG_PAGE];
  assign zero_flag_o = flags[`FLG_ZERO];
  assign pass_next_flag_o = flags[`FLG_PASS];
  assign half_carry_flag_o = flags[`FLG_HALF];
  assign carry_flag_o = flags[`FLG_CARRY];
  assign chained_load_flag_word_o = flags[`FLG_WORD];
  assign chained_load_flag_byte_o = flags[`FLG_BYTE];

endmodule // cmp_skip_page_unit

`default_nettype wire

// [tb/cmp_skip_page_sva.sv]
// assertions on the compare/skip and page arithmetic unit ports
// assumes one clock domain and an async active-low reset
`timescale 1ns/1ps
`default_nettype none
module cmp_skip_page_sva (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic instr_valid_i,
  input wire logic [7:0] byte1_i,
  input wire logic [7:0] byte2_i,
  input wire logic [7:0] byte3_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic discarded_o,
  input wire logic foreign_o,
  input wire logic mem_rd_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic special_rd_o,
  input wire logic [3:0] special_set_sel_o,
  input wire logic [7:0] acc_o,
  input wire logic [7:0] page_o,
  input wire logic pass_next_flag_o,
  input wire logic carry_flag_o,
  input wire logic chained_load_flag_word_o,
  input wire logic chained_load_flag_byte_o
);
  logic [7:0] b1_q;
  logic [7:0] b2_q;
  logic [7:0] b3_q;
  wire take = ce_i && !busy_o && instr_valid_i;
  always @(posedge core_clk_i) begin
    b1_q <= byte1_i;
    b2_q <= byte2_i;
    b3_q <= byte3_i;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_ACC_TIME: assert property (take && byte1_i[7:6] == 2'h1 && byte1_i[3:0] == 4'h7
    |=> busy_o [*7] ##1 done_o) else $error("acc form timing wrong");
  AST_REG_TIME: assert property (take && byte1_i == 8'h74 && byte2_i[7:6] == 2'h1 && byte2_i[3]
    |-> ##12 done_o) else $error("register form timing wrong");
  AST_SREG_TIME: assert property ($rose(special_rd_o) |-> ##14 done_o)
    else $error("special form timing wrong");
  AST_PAGE_TIME: assert property ($rose(mem_rd_o) |-> ##14 done_o)
    else $error("page form timing wrong");
  AST_MEM_ADDR: assert property ($rose(mem_rd_o) |-> mem_addr_o == {page_o, b3_q})
    else $error("page address wrong");
  AST_MEM_SRC: assert property ($rose(mem_rd_o) |-> b1_q == 8'h74 && b2_q[7])
    else $error("memory read outside page form");
  AST_SREG_SEL: assert property ($rose(special_rd_o) |-> b1_q == 8'h64
    && special_set_sel_o == {b2_q[7], b2_q[2:0]}) else $error("special select wrong");
  AST_CHAIN_CLR: assert property (done_o && !discarded_o && !foreign_o
    |-> !chained_load_flag_word_o && !chained_load_flag_byte_o) else $error("chain flags kept");
  AST_DISC_PASS: assert property (done_o && discarded_o |-> !pass_next_flag_o)
    else $error("pass flag kept after discard");
  AST_DISC_HOLD: assert property (busy_o && discarded_o |=> $stable(acc_o) && $stable(carry_flag_o))
    else $error("discard changed state");
endmodule // cmp_skip_page_sva

bind cmp_skip_page_unit cmp_skip_page_sva chk_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
  .instr_valid_i(instr_valid_i), .byte1_i(byte1_i), .byte2_i(byte2_i), .byte3_i(byte3_i),
  .busy_o(busy_o), .done_o(done_o), .discarded_o(discarded_o), .foreign_o(foreign_o),
  .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .special_rd_o(special_rd_o),
  .special_set_sel_o(special_set_sel_o), .acc_o(acc_o), .page_o(page_o),
  .pass_next_flag_o(pass_next_flag_o), .carry_flag_o(carry_flag_o),
  .chained_load_flag_word_o(chained_load_flag_word_o), .chained_load_flag_byte_o(chained_load_flag_byte_o));
`default_nettype wire

// [tb/operand_source_model.sv]
// far-side model: data memory and special registers answering reads
// assumes one-cycle read strobes; data valid for two edges, then inverted
`timescale 1ns/1ps
`default_nettype none
module operand_source_model (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] salt_i,
  input wire logic mem_rd_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic special_rd_i,
  input wire logic [3:0] special_sel_i,
  output wire logic [7:0] mem_data_o,
  output wire logic [7:0] special_data_o
);
  logic [1:0] mcnt;
  logic [1:0] scnt;
  logic [7:0] mv;
  logic [7:0] sv;
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mcnt <= '0;
      scnt <= '0;
      mv <= '0;
      sv <= '0;
    end else begin
      mcnt <= mem_rd_i ? 2'h2 : (mcnt != 2'h0 ? mcnt - 2'h1 : mcnt);
      scnt <= special_rd_i ? 2'h2 : (scnt != 2'h0 ? scnt - 2'h1 : scnt);
      if (mem_rd_i) mv <= mem_addr_i[15:8] ^ mem_addr_i[7:0] ^ salt_i;
      if (special_rd_i) sv <= {special_sel_i, ~special_sel_i} ^ salt_i;
    end
  end
  assign #1 mem_data_o = mcnt != 2'h0 ? mv : ~mv;
  assign #1 special_data_o = scnt != 2'h0 ? sv : ~sv;
endmodule // operand_source_model
`default_nettype wire

// [tb/cmp_skip_page_unit_tb.sv]
// random and directed bench for cmp_skip_page_unit
// assumes operand_source_model on the read side and the bound checker
`timescale 1ns/1ps
`default_nettype none
module cmp_skip_page_unit_tb;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic flag_wr_i = 1'b0;
  logic [7:0] byte1_i = '0, byte2_i = '0, byte3_i = '0, reg_wr_data_i = '0, salt = '0;
  logic [1:0] other_len_i = 2'h1;
  logic [4:0] other_alt_states_i = 5'h01;
  logic [2:0] reg_wr_sel_i = '0;
  logic [5:0] flag_wr_data_i = '0;
  wire [7:0] mem_data_i, special_data_i, acc_o, page_o;
  wire [15:0] mem_addr_o;
  wire [3:0] special_set_sel_o;
  wire [1:0] instr_len_o;
  wire [4:0] instr_states_o;
  wire busy_o, done_o, disc_o, for_o, mem_rd_o, sp_rd_o, zf, pf, hf, cf, wf, bf;
  int error_cnt = 0, checked = 0, seed = 83;
  logic [7:0] regs [8] = '{default: 8'h00};
  logic [3:0] sv [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hb, 4'hd};
  logic [3:0] iv [5] = '{4'h4, 4'ha, 4'hc, 4'he, 4'hf};
  logic [7:0] pgop [6] = '{8'hc0, 8'hd0, 8'ha0, 8'he0, 8'hf0, 8'hb0};
  always #2.5 core_clk_i = ~core_clk_i;
  cmp_skip_page_unit dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
    .instr_valid_i(instr_valid_i), .byte1_i(byte1_i), .byte2_i(byte2_i), .byte3_i(byte3_i),
    .other_len_i(other_len_i), .other_alt_states_i(other_alt_states_i), .reg_wr_i(reg_wr_i),
    .reg_wr_sel_i(reg_wr_sel_i), .reg_wr_data_i(reg_wr_data_i), .flag_wr_i(flag_wr_i),
    .flag_wr_data_i(flag_wr_data_i), .mem_data_i(mem_data_i), .special_data_i(special_data_i),
    .busy_o(busy_o), .done_o(done_o), .discarded_o(disc_o), .foreign_o(for_o), .instr_len_o(instr_len_o),
    .instr_states_o(instr_states_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .special_rd_o(sp_rd_o),
    .special_set_sel_o(special_set_sel_o), .acc_o(acc_o), .page_o(page_o), .zero_flag_o(zf),
    .pass_next_flag_o(pf), .half_carry_flag_o(hf), .carry_flag_o(cf), .chained_load_flag_word_o(wf),
    .chained_load_flag_byte_o(bf));
  operand_source_model src (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .salt_i(salt), .mem_rd_i(mem_rd_o),
    .mem_addr_i(mem_addr_o), .special_rd_i(sp_rd_o), .special_sel_i(special_set_sel_o),
    .mem_data_o(mem_data_i), .special_data_o(special_data_i));

  function automatic [13:0] model(input int k, input [1:0] op, input [3:0] s, input [7:0] a,
    input [7:0] x, input [7:0] y, input [5:0] f);
    logic [8:0] w;
    logic [4:0] h;
    logic c;
    c = (s == 4'h1 || s == 4'h4) ? f[2] : 1'b0;
    if (k == 3) begin
      w = (s > 4'h2) ? {1'b0, a} - x - c : {1'b0, a} + x + c;
      h = (s > 4'h2) ? {1'b0, a[3:0]} - x[3:0] - c : {1'b0, a[3:0]} + x[3:0] + c;
      return {w[7:0], w[7:0] == 8'h00, (s == 4'h2 || s == 4'h5) && !w[8], h[4], w[8], 2'h0};
    end
    w = op[1] ? {1'b0, x} - y : {1'b0, x & y};
    h = {1'b0, x[3:0]} - y[3:0];
    if (!op[1]) {h[4], w[8]} = f[3:2];
    return {a, w[7:0] == 8'h00, op[0] == (w[7:0] == 8'h00), h[4], w[8], 2'h0};
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic load(input [2:0] r, input [7:0] v, input [5:0] fl);
    @(posedge core_clk_i);
    #1;
    reg_wr_i = 1'b1;
    reg_wr_sel_i = r;
    reg_wr_data_i = v;
    flag_wr_i = 1'b1;
    flag_wr_data_i = fl;
    regs[r] = v;
    @(posedge core_clk_i);
    #1;
    reg_wr_i = 1'b0;
    flag_wr_i = 1'b0;
  endtask

  task automatic exec(input int k, input [1:0] op, input int i, input [7:0] v, input [7:0] y, input [5:0] fl);
    logic [3:0] s;
    logic [7:0] x;
    logic [13:0] e;
    logic [4:0] es;
    logic [1:0] el;
    int n;
    s = k == 2 ? sv[i % 11] : k == 4 ? iv[i % 5] : k == 3 ? 4'(i % 6) : 4'(i % 8);
    salt = 8'($random(seed));
    other_len_i = 2'($unsigned($random(seed)) % 3 + 1);
    other_alt_states_i = 5'($unsigned($random(seed)) % 31 + 1);
    load(3'h1, v, fl);
    if (k == 1) load(s[2:0], v, fl);
    if (k == 3) load(3'h0, 8'($random(seed)), fl);
    x = k == 1 ? regs[s[2:0]] : k == 2 ? {s, ~s} ^ salt : k == 3 ? regs[0] ^ y ^ salt : regs[1];
    e = (fl[4] || k == 4) ? {regs[1], fl & 6'h2f} : model(k, op, s, regs[1], x, y, fl);
    el = k == 4 ? other_len_i : (k == 0 ? 2'h2 : 2'h3);
    es = k == 4 ? (fl[4] ? other_alt_states_i : 5'h01) : k == 0 ? 5'h07 : (k == 1 || fl[4]) ? 5'h0b : 5'h0e;
    byte1_i = k == 0 ? {2'h1, op, 4'h7} : (k == 1 || k == 3) ? 8'h74 : 8'h64;
    byte2_i = k == 0 ? y : k == 1 ? {2'h1, op, 1'b1, s[2:0]} : k == 3 ? pgop[s] : {s[3], 1'b1, op, 1'b1, s[2:0]};
    byte3_i = y;
    instr_valid_i = 1'b1;
    @(posedge core_clk_i);
    #1;
    instr_valid_i = 1'b0;
    reg_wr_i = 1'b1;
    reg_wr_data_i = ~e[13:6];
    flag_wr_i = 1'b1;
    flag_wr_data_i = ~e[5:0];
    n = 0;
    while (done_o !== 1'b1 && n < 40) begin
      @(posedge core_clk_i);
      #1;
      n++;
      reg_wr_i = 1'b0;
      flag_wr_i = 1'b0;
    end
    regs[1] = e[13:6];
    chk("acc", e[13:6], acc_o);
    chk("flags", {2'h0, e[5:0]}, {2'h0, zf, pf, hf, cf, wf, bf});
    chk("page", regs[0], page_o);
    chk("len", {6'h00, el}, {6'h00, instr_len_o});
    chk("states", {3'h0, es}, {3'h0, instr_states_o});
    chk("cycles", {3'h0, es}, 8'(n));
    chk("skipped", {7'h00, fl[4]}, {7'h00, disc_o});
    chk("foreign", {7'h00, k == 4 && !fl[4]}, {7'h00, for_o});
  endtask

  task end_sim;
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #400000;
    error_cnt++;
    end_sim;
  end

  initial begin
    int k;
    repeat (10) @(posedge core_clk_i);
    #1;
    rst_b_i = 1'b1;
    for (int j = 0; j < 5; j++) for (int op = 0; op < 4; op++) begin
      exec(j, 2'(op), op, 8'h80, 8'h80, 6'h2b);
      exec(j, 2'(op), op, 8'h3c, 8'h0f, 6'h1f);
    end
    for (int i = 0; i < 11; i++) begin
      exec(2, 2'(i), i, 8'h00, 8'(i), 6'h03);
      exec(4, 2'(i), i, 8'h00, 8'h00, 6'h00);
      exec(1, 2'h3, i, 8'h5a, 8'h5a, 6'h03);
      exec(3, 2'h0, i, 8'hff, 8'(i), 6'h07);
    end
    repeat (300) begin
      k = $unsigned($random(seed)) % 5;
      exec(k, 2'($random(seed)), $unsigned($random(seed)) % 64, 8'($random(seed)), 8'($random(seed)),
        6'($random(seed)));
    end
    end_sim;
  end
endmodule // cmp_skip_page_unit_tb
`default_nettype wire
